//--- include/mab_cfg.svh
// microcore addressing and branch constants: opcode field position, widths, reset values
// assumes inclusion by bare name from the package and design files
`ifndef MAB_CFG_SVH
`define MAB_CFG_SVH
`define MAB_PC_W 16
`define MAB_DADDR_W 10
`define MAB_BASE_W 6
`define MAB_REL_W 5
`define MAB_REG_W 16
`define MAB_SEL_W 3
`define MAB_OP_LSB 11
`define MAB_PC_RST 16'h0000
`define MAB_BASE_RST 6'h00
`define MAB_REL_MAX 5'h0F
`define MAB_REL_MIN 5'h10
`define MAB_SHIFT_BYTE 8
`define MAB_PC_STEP 16'h0001
`define MAB_FLAG_ALL 16'hFFFF
`endif

//--- include/mab_pkg.sv
// microcore addressing and branch types
// assumes mab_cfg.svh on the include path
`include "mab_cfg.svh"
package mab_pkg;
  typedef enum logic [4:0] {
    MAB_OP_NOP = 5'h00,
    MAB_OP_LOAD = 5'h01,
    MAB_OP_CP = 5'h02,
    MAB_OP_SET_BASE = 5'h03,
    MAB_OP_SET_JT1 = 5'h04,
    MAB_OP_SET_JT2 = 5'h05,
    MAB_OP_JMP_FAR = 5'h06,
    MAB_OP_JMP_REL = 5'h07,
    MAB_OP_JSR_FAR = 5'h08,
    MAB_OP_JSR_REL = 5'h09,
    MAB_OP_RET_SUB = 5'h0A,
    MAB_OP_JCOND_FAR = 5'h0B,
    MAB_OP_JCOND_REL = 5'h0C,
    MAB_OP_REQ_IRQ = 5'h0D,
    MAB_OP_RET_IRQ = 5'h0E,
    MAB_OP_LD_CNT_ALU = 5'h0F,
    MAB_OP_LD_CNT_RAM = 5'h10,
    MAB_OP_LD_IMM_HI = 5'h11,
    MAB_OP_LD_IMM_LO = 5'h12,
    MAB_OP_MUL = 5'h13,
    MAB_OP_MULI = 5'h14,
    MAB_OP_AND = 5'h15,
    MAB_OP_OR = 5'h16,
    MAB_OP_XOR = 5'h17,
    MAB_OP_NOT = 5'h18,
    MAB_OP_BYTE_SHIFT_LEFT = 5'h19,
    MAB_OP_BYTE_SHIFT_RIGHT = 5'h1A,
    MAB_OP_SHIFT = 5'h1B,
    MAB_OP_CLR_START = 5'h1C,
    MAB_OP_RST_REGS = 5'h1D
  } mab_op_t;
  typedef enum logic [1:0] {
    MAB_ST_FETCH = 2'b00,
    MAB_ST_EXEC = 2'b01,
    MAB_ST_MEM = 2'b11
  } mab_state_t;
endpackage

//--- hdl/mab_rel_target.sv
// relative branch target: current line plus signed 5-bit offset
// assumes purely combinational use inside the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "mab_cfg.svh"
module mab_rel_target #(
  parameter int PC_W = `MAB_PC_W
) (
  input wire logic [PC_W-1:0] cur_line,
  input wire logic [`MAB_REL_W-1:0] rel_ofs,
  output logic [PC_W-1:0] target
);
  initial begin
    if (PC_W < `MAB_REL_W) begin
      $error("pc width too small");
    end
  end
  always_comb begin
    target = cur_line + {{(PC_W-`MAB_REL_W){rel_ofs[`MAB_REL_W-1]}}, rel_ofs}; // RQ7 RQ8
  end
endmodule
`default_nettype wire

//--- hdl/mab_core.sv
// microcore operand addressing and program flow sequencer
// assumes asynchronous code and data ram reads, data valid in the same cycle the registered address is held
//
// Contract
// [RQ1] immediate mode: ram address from operand
// [RQ2] direct mode: register from operand code
// [RQ3] far jumps use preloaded jump registers
// [RQ4] far jump loads pc from jump register
// [RQ5] indexed address adds base offset
// [RQ6] set-base writes base offset register
// [RQ7] relative reach minus sixteen to fifteen
// [RQ8] offset is 5-bit two's complement
// [RQ9] relative jump lands offset lines away
// [RQ10] immediate register upper and lower loads
// [RQ11] far and relative calls, return
// [RQ12] conditional far and relative branches
// [RQ13] software interrupt request and return
// [RQ14] counter load from alu or ram
// [RQ15] memory load and register copy
// [RQ16] multiply writes result register pair
// [RQ17] mask ops with immediate, invert
// [RQ18] byte shifts left and right
// [RQ19] clear start latches, reset registers
// [RQ20] 16-bit pc increments per fetch
// [RQ21] base offset register six bits wide
// [RQ22] call saves return, return restores
`timescale 1ns/1ns
`default_nettype none
`include "mab_cfg.svh"
module mab_core #(
  parameter int PC_W = `MAB_PC_W,
  parameter int DADDR_W = `MAB_DADDR_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  output logic [PC_W-1:0] code_addr,
  input wire logic [15:0] code_data,
  output logic [DADDR_W-1:0] data_addr,
  input wire logic [15:0] data_rdata,
  input wire logic [15:0] cond_flags,
  output logic [15:0] counter_value,
  output logic counter_load,
  output logic [15:0] predrv_out,
  output logic irq_req,
  output logic start_latch_clr,
  output logic [15:0] alu_reg0,
  output logic [15:0] imm_reg,
  output logic [31:0] mul_result,
  output logic [`MAB_BASE_W-1:0] base_offset
);
  import mab_pkg::*;

  initial begin
    if (PC_W != `MAB_PC_W || DADDR_W < `MAB_BASE_W) begin
      $error("unsupported width");
    end
  end

  // instruction word: [15:11] opcode, [10:8] register select, [7] index enable,
  // [6:0] address operand / immediate; relative offset in [4:0]; cond bit in [3:0] (far) or [8:5] (relative)
  typedef struct packed {
    mab_state_t st;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] cur;
    logic [15:0] ins;
    logic [PC_W-1:0] jt1;
    logic [PC_W-1:0] jt2;
    logic [PC_W-1:0] ret_sub;
    logic [PC_W-1:0] ret_irq;
    logic in_irq;
    logic [`MAB_BASE_W-1:0] base;
    logic [7:0][15:0] regs;
    logic [DADDR_W-1:0] daddr;
    logic [15:0] cnt;
    logic cnt_ld;
    logic [15:0] pout;
    logic irq;
    logic sl_clr;
  } mab_state_reg_t;

  mab_state_reg_t r;
  mab_state_reg_t next_r;
  logic [PC_W-1:0] rel_tgt;

  function automatic logic [DADDR_W-1:0] eff_addr(input logic [15:0] ins,
                                                  input logic [`MAB_BASE_W-1:0] base);
    logic [DADDR_W-1:0] a;
    a = DADDR_W'(ins[6:0]); // RQ1
    if (ins[7]) begin
      a = a + DADDR_W'(base); // RQ5
    end
    return a;
  endfunction

  mab_rel_target #(.PC_W(PC_W)) u_rel (
    .cur_line(r.cur),
    .rel_ofs(r.ins[`MAB_REL_W-1:0]),
    .target(rel_tgt)
  );

  mab_op_t op;
  logic [2:0] sel;
  logic [2:0] src;
  logic cond_ok;

  always_comb begin
    op = mab_op_t'(r.ins[15:`MAB_OP_LSB]);
    sel = r.ins[10:8]; // RQ2
    src = r.ins[2:0];
    cond_ok = cond_flags[r.ins[3:0]];
    next_r = r;
    next_r.cnt_ld = 1'b0;
    next_r.irq = 1'b0;
    next_r.sl_clr = 1'b0;
    case (r.st)
      MAB_ST_FETCH: begin
        next_r.cur = r.pc;
        next_r.pc = r.pc + `MAB_PC_STEP; // RQ20
        next_r.st = MAB_ST_EXEC;
      end
      MAB_ST_EXEC: begin
        next_r.ins = code_data;
        next_r.st = MAB_ST_MEM;
      end
      default: begin
        next_r.st = MAB_ST_FETCH;
        case (op)
          MAB_OP_LOAD: begin
            next_r.daddr = eff_addr(r.ins, r.base);
            next_r.regs[sel] = data_rdata; // RQ15
          end
          MAB_OP_CP: begin
            next_r.regs[sel] = r.regs[src]; // RQ15 RQ2
          end
          MAB_OP_SET_BASE: begin
            next_r.base = r.ins[`MAB_BASE_W-1:0]; // RQ6 RQ21
          end
          MAB_OP_SET_JT1: begin
            next_r.jt1 = PC_W'(r.ins[10:0]); // RQ3
          end
          MAB_OP_SET_JT2: begin
            next_r.jt2 = PC_W'(r.ins[10:0]); // RQ3
          end
          MAB_OP_JMP_FAR: begin
            next_r.pc = r.ins[0] ? r.jt2 : r.jt1; // RQ4
          end
          MAB_OP_JMP_REL: begin
            next_r.pc = rel_tgt; // RQ9
          end
          MAB_OP_JSR_FAR: begin
            next_r.ret_sub = r.pc; // RQ22
            next_r.pc = r.ins[0] ? r.jt2 : r.jt1; // RQ11
          end
          MAB_OP_JSR_REL: begin
            next_r.ret_sub = r.pc; // RQ22
            next_r.pc = rel_tgt; // RQ11
          end
          MAB_OP_RET_SUB: begin
            next_r.pc = r.ret_sub; // RQ22
          end
          MAB_OP_JCOND_FAR: begin
            if (cond_ok) begin
              next_r.pc = r.ins[4] ? r.jt2 : r.jt1; // RQ12
            end
          end
          MAB_OP_JCOND_REL: begin
            if (cond_flags[r.ins[8:5]]) begin
              next_r.pc = rel_tgt; // RQ12
            end
          end
          MAB_OP_REQ_IRQ: begin
            next_r.irq = 1'b1; // RQ13
            next_r.ret_irq = r.pc;
            next_r.in_irq = 1'b1;
          end
          MAB_OP_RET_IRQ: begin
            if (r.in_irq) begin
              next_r.pc = r.ret_irq; // RQ13
              next_r.in_irq = 1'b0;
            end
          end
          MAB_OP_LD_CNT_ALU: begin
            next_r.cnt = r.regs[src]; // RQ14
            next_r.cnt_ld = 1'b1;
            next_r.pout = {8'h00, r.ins[10:3]};
          end
          MAB_OP_LD_CNT_RAM: begin
            next_r.daddr = eff_addr(r.ins, r.base);
            next_r.cnt = data_rdata; // RQ14
            next_r.cnt_ld = 1'b1;
            next_r.pout = {8'h00, 1'b0, r.ins[10:8], 4'h0};
          end
          MAB_OP_LD_IMM_HI: begin
            next_r.regs[5][15:8] = r.ins[7:0]; // RQ10
          end
          MAB_OP_LD_IMM_LO: begin
            next_r.regs[5][7:0] = r.ins[7:0]; // RQ10
          end
          MAB_OP_MUL: begin
            {next_r.regs[6], next_r.regs[7]} = r.regs[sel] * r.regs[src]; // RQ16
          end
          MAB_OP_MULI: begin
            {next_r.regs[6], next_r.regs[7]} = r.regs[sel] * {12'h000, r.ins[3:0]}; // RQ16
          end
          MAB_OP_AND: begin
            next_r.regs[sel] = r.regs[sel] & r.regs[5]; // RQ17
          end
          MAB_OP_OR: begin
            next_r.regs[sel] = r.regs[sel] | r.regs[5]; // RQ17
          end
          MAB_OP_XOR: begin
            next_r.regs[sel] = r.regs[sel] ^ r.regs[5]; // RQ17
          end
          MAB_OP_NOT: begin
            next_r.regs[sel] = ~r.regs[sel]; // RQ17
          end
          MAB_OP_BYTE_SHIFT_LEFT: begin
            next_r.regs[sel] = r.regs[sel] << `MAB_SHIFT_BYTE; // RQ18
          end
          MAB_OP_BYTE_SHIFT_RIGHT: begin
            next_r.regs[sel] = r.regs[sel] >> `MAB_SHIFT_BYTE; // RQ18
          end
          MAB_OP_SHIFT: begin
            if (r.ins[7]) begin
              next_r.regs[sel] = r.ins[6] ? ($signed(r.regs[sel]) >>> r.ins[3:0])
                                          : (r.regs[sel] >> r.ins[3:0]); // RQ18
            end else begin
              next_r.regs[sel] = r.regs[sel] << r.ins[3:0]; // RQ18
            end
          end
          MAB_OP_CLR_START: begin
            next_r.sl_clr = 1'b1; // RQ19
          end
          MAB_OP_RST_REGS: begin
            for (int i = 0; i < 8; i++) begin
              if (r.ins[i]) begin
                next_r.regs[i] = 16'h0000; // RQ19
              end
            end
          end
          default: begin
          end
        endcase
      end
    endcase
  end

  // data ram address is computed during exec and registered on the edge into mem, so data is ready in mem state
  logic [DADDR_W-1:0] daddr_early;
  always_comb begin
    daddr_early = eff_addr(code_data, r.base); // RQ1 RQ5
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= MAB_ST_FETCH;
      r.pc <= `MAB_PC_RST;
      r.base <= `MAB_BASE_RST;
      code_addr <= '0;
      data_addr <= '0;
    end else if (clk_en) begin
      r <= next_r;
      if (r.st == MAB_ST_FETCH) begin
        code_addr <= r.pc;
      end
      if (r.st == MAB_ST_EXEC) begin
        data_addr <= daddr_early;
      end
    end
  end

  always_comb begin
    counter_value = r.cnt;
    counter_load = r.cnt_ld;
    predrv_out = r.pout;
    irq_req = r.irq;
    start_latch_clr = r.sl_clr;
    alu_reg0 = r.regs[0];
    imm_reg = r.regs[5];
    mul_result = {r.regs[6], r.regs[7]};
    base_offset = r.base;
  end

  sequence s_fetch;
    r.st == MAB_ST_FETCH && clk_en;
  endsequence
  sequence s_jmp_rel;
    r.st == MAB_ST_MEM && clk_en && op == MAB_OP_JMP_REL;
  endsequence

  property p_pc_inc;
    @(posedge clk) disable iff (sys_rst) s_fetch |=> r.pc == $past(r.pc) + `MAB_PC_STEP;
  endproperty
  property p_rel;
    @(posedge clk) disable iff (sys_rst) s_jmp_rel |=> r.pc == $past(rel_tgt);
  endproperty

  AST_PC_INC: assert property (p_pc_inc) else $error("pc did not advance"); // RQ20
  AST_REL_JUMP: assert property (p_rel) else $error("relative target wrong"); // RQ9
  AST_REL_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
    (rel_tgt - r.cur + 16'h0010) <= 16'h001F) else $error("relative out of range"); // RQ7
  AST_FAR_JUMP: assert property (@(posedge clk) disable iff (sys_rst)
    r.st == MAB_ST_MEM && clk_en && op == MAB_OP_JMP_FAR && !r.ins[0] |=> r.pc == $past(r.jt1))
    else $error("far jump target wrong"); // RQ4
  AST_BASE: assert property (@(posedge clk) disable iff (sys_rst)
    r.st == MAB_ST_MEM && clk_en && op == MAB_OP_SET_BASE |=> base_offset == $past(r.ins[5:0]))
    else $error("base not written"); // RQ6
  AST_RET: assert property (@(posedge clk) disable iff (sys_rst)
    r.st == MAB_ST_MEM && clk_en && op == MAB_OP_RET_SUB |=> r.pc == $past(r.ret_sub))
    else $error("return address wrong"); // RQ22
  AST_INDEX: assert property (@(posedge clk) disable iff (sys_rst)
    r.st == MAB_ST_EXEC && clk_en && code_data[7] |=>
    data_addr == DADDR_W'(DADDR_W'($past(code_data[6:0])) + DADDR_W'($past(r.base))))
    else $error("indexed address wrong"); // RQ5
  AST_IMM_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
    r.st == MAB_ST_EXEC && clk_en && !code_data[7] |=> data_addr == DADDR_W'($past(code_data[6:0])))
    else $error("immediate address wrong"); // RQ1
  AST_CNT_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    counter_load |=> !counter_load) else $error("counter load not a pulse"); // RQ14
  AST_IMM_HI: assert property (@(posedge clk) disable iff (sys_rst)
    r.st == MAB_ST_MEM && clk_en && op == MAB_OP_LD_IMM_HI |=>
    imm_reg[15:8] == $past(r.ins[7:0]) && imm_reg[7:0] == $past(r.regs[5][7:0]))
    else $error("immediate high load wrong"); // RQ10
endmodule
`default_nettype wire

//--- testbench/mab_ram_model.sv
// partner model: code and data ram banks seen by the sequencer
// assumes reads answer from the address the core holds, ready within the cycle
`timescale 1ns/1ns
`default_nettype none
module mab_ram_model (
  input wire logic [15:0] code_addr,
  output logic [15:0] code_data,
  input wire logic [9:0] data_addr,
  output logic [15:0] data_rdata
);
  logic [15:0] code_mem [256];
  logic [15:0] data_mem [1024];
  initial begin
    for (int i = 0; i < 1024; i++) begin
      data_mem[i] = 16'hA000 ^ 16'(i);
      if (i < 256) begin
        code_mem[i] = 16'h0000;
      end
    end
  end
  // code lines beyond the bank wrap on the low address bits
  assign code_data = code_mem[code_addr[7:0]];
  assign data_rdata = data_mem[data_addr];
endmodule
`default_nettype wire

//--- testbench/microcore_addressing_branch_tb.sv
// bench for the addressing and program flow sequencer
// assumes mab_pkg compiled first and the ram model beside the core
`timescale 1ns/1ns
`default_nettype none
module microcore_addressing_branch_tb;
  import mab_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [15:0] cond_flags = 16'h0000;
  logic [15:0] code_addr, code_data, data_rdata, counter_value, predrv_out, alu_reg0, imm_reg;
  logic [9:0] data_addr;
  logic counter_load, irq_req, start_latch_clr;
  logic [31:0] mul_result;
  logic [5:0] base_offset;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_load, n_irq, n_clr;

  mab_core DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .code_addr(code_addr), .code_data(code_data),
    .data_addr(data_addr), .data_rdata(data_rdata), .cond_flags(cond_flags), .counter_value(counter_value),
    .counter_load(counter_load), .predrv_out(predrv_out), .irq_req(irq_req), .start_latch_clr(start_latch_clr),
    .alu_reg0(alu_reg0), .imm_reg(imm_reg), .mul_result(mul_result), .base_offset(base_offset));
  mab_ram_model ram (.code_addr(code_addr), .code_data(code_data), .data_addr(data_addr), .data_rdata(data_rdata));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    n_load += counter_load;
    n_irq += irq_req;
    n_clr += start_latch_clr;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] ins(input mab_op_t op, input logic [10:0] f);
    return {op, f};
  endfunction

  function automatic logic [15:0] dpat(input int a);
    return 16'hA000 ^ 16'(a);
  endfunction

  task prog(input int a, input logic [15:0] w);
    ram.code_mem[a] = w;
  endtask

  task clear();
    for (int i = 0; i < 256; i++) begin
      ram.code_mem[i] = 16'h0000;
    end
  endtask

  // reset, then release so the next edge fetches line zero
  task start();
    @(posedge clk) sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(code_addr, 32'h0);
    chk(base_offset, 32'h0);
    @(posedge clk) sys_rst <= 1'b0;
    n_load = 0;
    n_irq = 0;
    n_clr = 0;
  endtask

  // run n whole instructions, land just after the last mem state edge
  task run(input int n);
    start();
    repeat (3 * n) @(posedge clk);
    #1;
  endtask

  task next_fetch(input logic [15:0] exp);
    @(posedge clk);
    #1;
    chk(code_addr, exp);
  endtask

  task t_addr();
    clear();
    prog(0, ins(MAB_OP_LOAD, 11'h005));
    prog(1, ins(MAB_OP_SET_BASE, 11'h007));
    prog(2, ins(MAB_OP_LOAD, 11'h081));
    prog(3, ins(MAB_OP_SET_BASE, 11'h03F));
    prog(4, ins(MAB_OP_LOAD, 11'h0FF));
    run(1);
    chk(alu_reg0, dpat(5));
    chk(data_addr, 32'h5);
    run(3);
    chk(base_offset, 32'h7);
    chk(alu_reg0, dpat(8));
    run(5);
    chk(base_offset, 32'h3F);
    chk(alu_reg0, dpat(10'h0BE));
  endtask

  task t_far();
    clear();
    prog(0, ins(MAB_OP_SET_JT1, 11'h020));
    prog(1, ins(MAB_OP_SET_JT2, 11'h040));
    prog(2, ins(MAB_OP_JMP_FAR, 11'h001));
    prog(16'h40, ins(MAB_OP_JMP_FAR, 11'h000));
    run(0);
    next_fetch(16'h0000);
    run(1);
    next_fetch(16'h0001);
    run(3);
    next_fetch(16'h0040);
    run(4);
    next_fetch(16'h0020);
  endtask

  task t_rel();
    logic [4:0] tab [5];
    logic [4:0] o;
    tab = '{5'h0F, 5'h01, 5'h00, 5'h1F, 5'h10};
    for (int i = 0; i < 5; i++) begin
      o = tab[i];
      clear();
      prog(0, ins(MAB_OP_SET_JT1, 11'h030));
      prog(1, ins(MAB_OP_JMP_FAR, 11'h000));
      prog(16'h30, ins(MAB_OP_JMP_REL, {6'h00, o}));
      run(3);
      next_fetch(16'h0030 + {{11{o[4]}}, o});
    end
  endtask

  task t_sub();
    clear();
    prog(0, ins(MAB_OP_SET_JT2, 11'h010));
    prog(1, ins(MAB_OP_JSR_FAR, 11'h001));
    prog(16'h10, ins(MAB_OP_RET_SUB, 11'h000));
    prog(2, ins(MAB_OP_JSR_REL, 11'h004));
    prog(6, ins(MAB_OP_RET_SUB, 11'h000));
    run(2);
    next_fetch(16'h0010);
    run(3);
    next_fetch(16'h0002);
    run(4);
    next_fetch(16'h0006);
    run(5);
    next_fetch(16'h0003);
  endtask

  task t_cond();
    for (int t = 0; t < 2; t++) begin
      clear();
      @(posedge clk) cond_flags <= (t == 1) ? 16'h0004 : 16'hFFFB;
      prog(0, ins(MAB_OP_SET_JT2, 11'h020));
      prog(1, ins(MAB_OP_JCOND_FAR, 11'h012));
      prog(2, ins(MAB_OP_JCOND_REL, 11'h045));
      prog(16'h20, ins(MAB_OP_JCOND_REL, 11'h045));
      run(2);
      next_fetch((t == 1) ? 16'h0020 : 16'h0002);
      run(3);
      next_fetch((t == 1) ? 16'h0025 : 16'h0003);
    end
  endtask

  task t_alu();
    logic [15:0] im, e3, e5, e7, e8, e9, e10;
    im = 16'hA53C;
    e3 = dpat(2) & im;
    e5 = dpat(3) | im;
    e7 = dpat(4) ^ im;
    e8 = ~e7;
    e9 = {e8[7:0], 8'h00};
    e10 = {8'h00, e9[15:8]};
    clear();
    prog(0, ins(MAB_OP_LD_IMM_HI, 11'h0A5));
    prog(1, ins(MAB_OP_LD_IMM_LO, 11'h03C));
    prog(2, ins(MAB_OP_LOAD, 11'h002));
    prog(3, ins(MAB_OP_AND, 11'h000));
    prog(4, ins(MAB_OP_LOAD, 11'h003));
    prog(5, ins(MAB_OP_OR, 11'h000));
    prog(6, ins(MAB_OP_LOAD, 11'h004));
    prog(7, ins(MAB_OP_XOR, 11'h000));
    prog(8, ins(MAB_OP_NOT, 11'h000));
    prog(9, ins(MAB_OP_BYTE_SHIFT_LEFT, 11'h000));
    prog(10, ins(MAB_OP_BYTE_SHIFT_RIGHT, 11'h000));
    prog(11, ins(MAB_OP_MUL, 11'h005));
    prog(12, ins(MAB_OP_MULI, 11'h003));
    prog(13, ins(MAB_OP_CP, 11'h005));
    run(1);
    chk(imm_reg, 32'hA500);
    run(2);
    chk(imm_reg, im);
    run(4);
    chk(alu_reg0, e3);
    run(6);
    chk(alu_reg0, e5);
    run(8);
    chk(alu_reg0, e7);
    run(9);
    chk(alu_reg0, e8);
    run(10);
    chk(alu_reg0, e9);
    run(11);
    chk(alu_reg0, e10);
    run(12);
    chk(mul_result, {16'h0000, e10} * {16'h0000, im});
    chk(alu_reg0, e10);
    run(13);
    chk(mul_result, {16'h0000, e10} * 32'h3);
    run(14);
    chk(alu_reg0, im);
  endtask

  task t_misc();
    clear();
    prog(0, ins(MAB_OP_LOAD, 11'h005));
    prog(1, ins(MAB_OP_LD_CNT_ALU, 11'h0A8));
    prog(2, ins(MAB_OP_LD_CNT_RAM, 11'h006));
    prog(3, ins(MAB_OP_REQ_IRQ, 11'h000));
    prog(4, ins(MAB_OP_CLR_START, 11'h000));
    prog(5, ins(MAB_OP_RST_REGS, 11'h001));
    prog(6, ins(MAB_OP_RET_IRQ, 11'h000));
    run(2);
    chk(counter_value, dpat(5));
    chk(predrv_out, 32'h15);
    run(3);
    chk(counter_value, dpat(6));
    run(7);
    chk(n_load, 32'h2);
    chk(n_irq, 32'h1);
    chk(n_clr, 32'h1);
    chk(alu_reg0, 32'h0);
    next_fetch(16'h0004);
  endtask

  initial begin
    t_addr();
    t_far();
    t_rel();
    t_sub();
    t_cond();
    t_alu();
    t_misc();
    report_and_stop();
  end
endmodule
`default_nettype wire
